// File: design/jtag_chain_pkg.sv
// Constants and types shared by the test-port data chains
package jtag_chain_pkg;

    // Instruction codes
    localparam int          IR_W         = 4;
    localparam logic [3:0]  IR_EXT_TEST  = 4'h0;
    localparam logic [3:0]  IR_INT_TEST  = 4'h1;
    localparam logic [3:0]  IR_SAMPLE    = 4'h2;
    localparam logic [3:0]  IR_ABORT     = 4'h8;
    localparam logic [3:0]  IR_DP_ACC    = 4'hA;
    localparam logic [3:0]  IR_AP_ACC    = 4'hB;
    localparam logic [3:0]  IR_IDENT     = 4'hE;
    localparam logic [3:0]  IR_BYPASS    = 4'hF;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;

    // Chain widths
    localparam int          ID_W         = 32;
    localparam int          ACC_W        = 35;
    localparam int          DATA_W       = 32;
    localparam int          ACK_W        = 3;
    localparam int          N_GPIO       = 8;
    localparam int          CELLS        = 3;
    localparam int          BSR_W        = CELLS * N_GPIO;
    localparam int          LEN_W        = 6;

    // Cell positions inside one pin group
    localparam int          CELL_IN      = 0;
    localparam int          CELL_OUT     = 1;
    localparam int          CELL_OE      = 2;

    // Capture values; identity value is arbitrary
    localparam logic [31:0] ID_VALUE     = 32'h0000_1001;
    localparam logic        BYPASS_CAP   = 1'h0;
    localparam logic [2:0]  ACK_WAIT     = 3'h1;

    // Request queue toward the debug port
    localparam int          FIFO_DEPTH   = 16;
    localparam int          SEL_W        = 2;
    localparam int          REQ_W        = ACC_W + SEL_W;
    localparam logic [1:0]  REQ_DP       = 2'h0;
    localparam logic [1:0]  REQ_AP       = 2'h1;
    localparam logic [1:0]  REQ_ABORT    = 2'h2;

    // Controller states, Gray steps along the common path
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EX1_DR   = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EX2_DR   = 4'h4,
        ST_UPD_DR   = 4'hC,
        ST_SEL_IR   = 4'hD,
        ST_CAP_IR   = 4'hF,
        ST_SHIFT_IR = 4'hE,
        ST_EX1_IR   = 4'hA,
        ST_PAUSE_IR = 4'hB,
        ST_EX2_IR   = 4'h9,
        ST_UPD_IR   = 4'h8
    } tap_state_t;

    // Chain selected between TDI and TDO
    typedef enum logic [2:0] {
        CH_BYPASS = 3'h0,
        CH_IDENT  = 3'h1,
        CH_BSR    = 3'h3,
        CH_DP     = 3'h2,
        CH_AP     = 3'h6,
        CH_ABORT  = 3'h7
    } chain_t;

endpackage

// File: design/jtag_data_chains.sv
// Test-port data chains, instruction decode and pad multiplexing
`timescale 1ns/100ps
module jtag_data_chains (
    input  wire logic                                 ref_clk_i,
    input  wire logic                                 rst_n_i,
    input  wire logic                                 tck_i,
    input  wire logic                                 tms_i,
    input  wire logic                                 tdi_i,
    input  wire logic                                 trst_n_i,
    output logic                                      tdo_o,
    output logic                                      tdo_oe_o,
    input  wire logic [jtag_chain_pkg::N_GPIO-1:0]    pad_in_i,
    input  wire logic [jtag_chain_pkg::N_GPIO-1:0]    core_out_i,
    input  wire logic [jtag_chain_pkg::N_GPIO-1:0]    core_oe_i,
    output logic      [jtag_chain_pkg::N_GPIO-1:0]    pad_out_o,
    output logic      [jtag_chain_pkg::N_GPIO-1:0]    pad_oe_o,
    output logic      [jtag_chain_pkg::N_GPIO-1:0]    core_in_o,
    input  wire logic [jtag_chain_pkg::DATA_W-1:0]    dbg_rdata_i,
    input  wire logic [jtag_chain_pkg::ACK_W-1:0]     dbg_ack_i,
    output logic                                      req_valid_o,
    output logic      [jtag_chain_pkg::ACC_W-1:0]     req_data_o,
    output logic      [jtag_chain_pkg::SEL_W-1:0]     req_sel_o,
    input  wire logic                                 req_ready_i
);
    localparam int N     = jtag_chain_pkg::N_GPIO;
    localparam int ACC_W = jtag_chain_pkg::ACC_W;
    localparam int BSR_W = jtag_chain_pkg::BSR_W;
    localparam int IR_W  = jtag_chain_pkg::IR_W;

    // Synchronised pin levels
    logic [3:0]   link_s;
    logic [N-1:0] pad_in_s;
    logic         tck_s;
    logic         tms_s;
    logic         tdi_s;
    logic         trst_n_s;
    logic         tck_d_reg;
    logic         tck_d_next;
    logic         tck_rise;
    logic         tck_fall;

    // Controller, instruction and data chain state
    jtag_chain_pkg::tap_state_t state_reg;
    jtag_chain_pkg::tap_state_t state_next;
    logic [IR_W-1:0]  ir_reg;
    logic [IR_W-1:0]  ir_next;
    logic [IR_W-1:0]  irsh_reg;
    logic [IR_W-1:0]  irsh_next;
    logic [ACC_W-1:0] dr_reg;
    logic [ACC_W-1:0] dr_next;
    logic [BSR_W-1:0] hold_reg;
    logic [BSR_W-1:0] hold_next;
    logic             wait_reg;
    logic             wait_next;
    logic             tdo_reg;
    logic             tdo_next;
    logic             tdo_oe_reg;
    logic             tdo_oe_next;
    logic [N-1:0]     pad_out_reg;
    logic [N-1:0]     pad_out_next;
    logic [N-1:0]     pad_oe_reg;
    logic [N-1:0]     pad_oe_next;
    logic [N-1:0]     core_in_reg;
    logic [N-1:0]     core_in_next;

    // Boundary capture and hold views per cell kind
    logic [BSR_W-1:0] bsr_cap;
    logic [N-1:0]     hold_in;
    logic [N-1:0]     hold_out;
    logic [N-1:0]     hold_oe;

    // Request path
    jtag_chain_pkg::chain_t chain;
    logic [ACC_W+1:0] push_data;
    logic             push_valid;
    logic             fifo_ready;

    sync_two_ff #(
        .W (4)
    ) u_link_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({trst_n_i, tdi_i, tms_i, tck_i}),
        .q_o       (link_s)
    );

    sync_two_ff #(
        .W (N)
    ) u_pad_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (pad_in_i),
        .q_o       (pad_in_s)
    );

    assign tck_s    = link_s[0];
    assign tms_s    = link_s[1];
    assign tdi_s    = link_s[2];
    assign trst_n_s = link_s[3];
    assign tck_rise = tck_s && !tck_d_reg;
    assign tck_fall = !tck_s && tck_d_reg;

    function automatic jtag_chain_pkg::chain_t decode_chain(
        input logic [IR_W-1:0] ir
    );
        if (ir == jtag_chain_pkg::IR_EXT_TEST ||
            ir == jtag_chain_pkg::IR_INT_TEST ||
            ir == jtag_chain_pkg::IR_SAMPLE) begin
            decode_chain = jtag_chain_pkg::CH_BSR;
        end else if (ir == jtag_chain_pkg::IR_ABORT) begin
            decode_chain = jtag_chain_pkg::CH_ABORT;
        end else if (ir == jtag_chain_pkg::IR_DP_ACC) begin
            decode_chain = jtag_chain_pkg::CH_DP;
        end else if (ir == jtag_chain_pkg::IR_AP_ACC) begin
            decode_chain = jtag_chain_pkg::CH_AP;
        end else if (ir == jtag_chain_pkg::IR_IDENT) begin
            decode_chain = jtag_chain_pkg::CH_IDENT;
        end else begin
            decode_chain = jtag_chain_pkg::CH_BYPASS;
        end
    endfunction

    // Length of the selected chain
    function automatic logic [5:0] chain_len(
        input jtag_chain_pkg::chain_t ch
    );
        case (ch)
            jtag_chain_pkg::CH_IDENT: chain_len = 6'(jtag_chain_pkg::ID_W);
            jtag_chain_pkg::CH_BSR:   chain_len = 6'(BSR_W);
            jtag_chain_pkg::CH_DP,
            jtag_chain_pkg::CH_AP,
            jtag_chain_pkg::CH_ABORT: chain_len = 6'(ACC_W);
            default:                  chain_len = 6'h01;
        endcase
    endfunction

    // Controller successor for one TCK rise
    function automatic jtag_chain_pkg::tap_state_t tap_step(
        input jtag_chain_pkg::tap_state_t s,
        input logic                       tms
    );
        case (s)
            jtag_chain_pkg::ST_RESET:    tap_step = tms ? jtag_chain_pkg::ST_RESET    : jtag_chain_pkg::ST_IDLE;
            jtag_chain_pkg::ST_IDLE:     tap_step = tms ? jtag_chain_pkg::ST_SEL_DR   : jtag_chain_pkg::ST_IDLE;
            jtag_chain_pkg::ST_SEL_DR:   tap_step = tms ? jtag_chain_pkg::ST_SEL_IR   : jtag_chain_pkg::ST_CAP_DR;
            jtag_chain_pkg::ST_CAP_DR:   tap_step = tms ? jtag_chain_pkg::ST_EX1_DR   : jtag_chain_pkg::ST_SHIFT_DR;
            jtag_chain_pkg::ST_SHIFT_DR: tap_step = tms ? jtag_chain_pkg::ST_EX1_DR   : jtag_chain_pkg::ST_SHIFT_DR;
            jtag_chain_pkg::ST_EX1_DR:   tap_step = tms ? jtag_chain_pkg::ST_UPD_DR   : jtag_chain_pkg::ST_PAUSE_DR;
            jtag_chain_pkg::ST_PAUSE_DR: tap_step = tms ? jtag_chain_pkg::ST_EX2_DR   : jtag_chain_pkg::ST_PAUSE_DR;
            jtag_chain_pkg::ST_EX2_DR:   tap_step = tms ? jtag_chain_pkg::ST_UPD_DR   : jtag_chain_pkg::ST_SHIFT_DR;
            jtag_chain_pkg::ST_UPD_DR:   tap_step = tms ? jtag_chain_pkg::ST_SEL_DR   : jtag_chain_pkg::ST_IDLE;
            jtag_chain_pkg::ST_SEL_IR:   tap_step = tms ? jtag_chain_pkg::ST_RESET    : jtag_chain_pkg::ST_CAP_IR;
            jtag_chain_pkg::ST_CAP_IR:   tap_step = tms ? jtag_chain_pkg::ST_EX1_IR   : jtag_chain_pkg::ST_SHIFT_IR;
            jtag_chain_pkg::ST_SHIFT_IR: tap_step = tms ? jtag_chain_pkg::ST_EX1_IR   : jtag_chain_pkg::ST_SHIFT_IR;
            jtag_chain_pkg::ST_EX1_IR:   tap_step = tms ? jtag_chain_pkg::ST_UPD_IR   : jtag_chain_pkg::ST_PAUSE_IR;
            jtag_chain_pkg::ST_PAUSE_IR: tap_step = tms ? jtag_chain_pkg::ST_EX2_IR   : jtag_chain_pkg::ST_PAUSE_IR;
            jtag_chain_pkg::ST_EX2_IR:   tap_step = tms ? jtag_chain_pkg::ST_UPD_IR   : jtag_chain_pkg::ST_SHIFT_IR;
            default:                     tap_step = tms ? jtag_chain_pkg::ST_SEL_DR   : jtag_chain_pkg::ST_IDLE;
        endcase
    endfunction

    assign chain = decode_chain(ir_reg);

    // Boundary cell layout per pin
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cells
            assign bsr_cap[g*jtag_chain_pkg::CELLS + jtag_chain_pkg::CELL_IN]
                = pad_in_s[g];
            assign bsr_cap[g*jtag_chain_pkg::CELLS + jtag_chain_pkg::CELL_OUT]
                = core_out_i[g];
            assign bsr_cap[g*jtag_chain_pkg::CELLS + jtag_chain_pkg::CELL_OE]
                = core_oe_i[g];
            assign hold_in[g]
                = hold_reg[g*jtag_chain_pkg::CELLS + jtag_chain_pkg::CELL_IN];
            assign hold_out[g]
                = hold_reg[g*jtag_chain_pkg::CELLS + jtag_chain_pkg::CELL_OUT];
            assign hold_oe[g]
                = hold_reg[g*jtag_chain_pkg::CELLS + jtag_chain_pkg::CELL_OE];
        end
    endgenerate

    // Controller, instruction and chain next values
    always_comb begin
        logic [5:0] len;
        len         = chain_len(chain);
        tck_d_next  = tck_s;
        state_next  = state_reg;
        ir_next     = ir_reg;
        irsh_next   = irsh_reg;
        dr_next     = dr_reg;
        hold_next   = hold_reg;
        wait_next   = wait_reg;
        tdo_next    = tdo_reg;
        tdo_oe_next = tdo_oe_reg;
        push_valid  = 1'b0;
        if (tck_rise) begin
            state_next = tap_step(state_reg, tms_s);
            case (state_reg)
                jtag_chain_pkg::ST_CAP_DR: begin
                    dr_next   = '0;
                    wait_next = 1'b0;
                    case (chain)
                        jtag_chain_pkg::CH_IDENT: begin
                            dr_next[jtag_chain_pkg::ID_W-1:0]
                                = jtag_chain_pkg::ID_VALUE;
                        end
                        jtag_chain_pkg::CH_BSR: begin
                            dr_next[BSR_W-1:0] = bsr_cap;
                        end
                        jtag_chain_pkg::CH_DP,
                        jtag_chain_pkg::CH_AP: begin
                            dr_next   = {dbg_rdata_i,
                                         fifo_ready ? dbg_ack_i
                                                    : jtag_chain_pkg::ACK_WAIT};
                            wait_next = !fifo_ready;
                        end
                        jtag_chain_pkg::CH_ABORT: begin
                            dr_next = '0;
                        end
                        default: begin
                            dr_next[0] = jtag_chain_pkg::BYPASS_CAP;
                        end
                    endcase
                end
                jtag_chain_pkg::ST_SHIFT_DR: begin
                    // Shift toward TDO, TDI at top
                    for (int i = 0; i < ACC_W; i++) begin
                        if (i == int'(len) - 1) begin
                            dr_next[i] = tdi_s;
                        end else if (i < ACC_W - 1) begin
                            dr_next[i] = dr_reg[i+1];
                        end else begin
                            dr_next[i] = 1'b0;
                        end
                    end
                end
                jtag_chain_pkg::ST_CAP_IR: begin
                    irsh_next = jtag_chain_pkg::IR_CAPTURE;
                end
                jtag_chain_pkg::ST_SHIFT_IR: begin
                    irsh_next = {tdi_s, irsh_reg[IR_W-1:1]};
                end
                default: begin
                end
            endcase
            if (state_next == jtag_chain_pkg::ST_UPD_DR) begin
                if (chain == jtag_chain_pkg::CH_BSR) begin
                    hold_next = dr_reg[BSR_W-1:0];
                end
                if (chain == jtag_chain_pkg::CH_ABORT ||
                    ((chain == jtag_chain_pkg::CH_DP ||
                      chain == jtag_chain_pkg::CH_AP) && !wait_reg)) begin
                    push_valid = 1'b1;
                end
            end
            if (state_next == jtag_chain_pkg::ST_UPD_IR) begin
                ir_next = irsh_reg;
            end
            if (state_next == jtag_chain_pkg::ST_RESET) begin
                ir_next = jtag_chain_pkg::IR_IDENT;
            end
        end
        if (tck_fall) begin
            // TDO changes on the falling edge
            tdo_oe_next = (state_reg == jtag_chain_pkg::ST_SHIFT_DR) ||
                          (state_reg == jtag_chain_pkg::ST_SHIFT_IR);
            tdo_next    = (state_reg == jtag_chain_pkg::ST_SHIFT_IR)
                          ? irsh_reg[0] : dr_reg[0];
        end
    end

    // Pad and core multiplexing
    always_comb begin
        pad_out_next = (ir_reg == jtag_chain_pkg::IR_EXT_TEST)
                       ? hold_out : core_out_i;
        pad_oe_next  = (ir_reg == jtag_chain_pkg::IR_EXT_TEST)
                       ? hold_oe : core_oe_i;
        core_in_next = (ir_reg == jtag_chain_pkg::IR_INT_TEST)
                       ? hold_in : pad_in_s;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !trst_n_s) begin
            state_reg   <= jtag_chain_pkg::ST_RESET;
            ir_reg      <= jtag_chain_pkg::IR_IDENT;
            irsh_reg    <= '0;
            dr_reg      <= '0;
            hold_reg    <= '0;
            wait_reg    <= 1'b0;
            tdo_reg     <= 1'b0;
            tdo_oe_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            ir_reg      <= ir_next;
            irsh_reg    <= irsh_next;
            dr_reg      <= dr_next;
            hold_reg    <= hold_next;
            wait_reg    <= wait_next;
            tdo_reg     <= tdo_next;
            tdo_oe_reg  <= tdo_oe_next;
        end
    end

    // Edge detector and pad registers, system reset only
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tck_d_reg   <= 1'b0;
            pad_out_reg <= '0;
            pad_oe_reg  <= '0;
            core_in_reg <= '0;
        end else begin
            tck_d_reg   <= tck_d_next;
            pad_out_reg <= pad_out_next;
            pad_oe_reg  <= pad_oe_next;
            core_in_reg <= core_in_next;
        end
    end

    // Access words tagged with their chain
    always_comb begin
        if (chain == jtag_chain_pkg::CH_AP) begin
            push_data = {jtag_chain_pkg::REQ_AP, dr_reg};
        end else if (chain == jtag_chain_pkg::CH_ABORT) begin
            push_data = {jtag_chain_pkg::REQ_ABORT, dr_reg};
        end else begin
            push_data = {jtag_chain_pkg::REQ_DP, dr_reg};
        end
    end

    // Queue toward the debug port; full shows as wait ack
    req_fifo #(
        .WIDTH (jtag_chain_pkg::REQ_W),
        .DEPTH (jtag_chain_pkg::FIFO_DEPTH)
    ) u_req_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_valid),
        .in_data_i   (push_data),
        .in_ready_o  (fifo_ready),
        .out_valid_o (req_valid_o),
        .out_data_o  ({req_sel_o, req_data_o}),
        .out_ready_i (req_ready_i)
    );

    assign tdo_o     = tdo_reg;
    assign tdo_oe_o  = tdo_oe_reg;
    assign pad_out_o = pad_out_reg;
    assign pad_oe_o  = pad_oe_reg;
    assign core_in_o = core_in_reg;
endmodule

// File: design/req_fifo.sv
// Request FIFO with registered head word
`timescale 1ns/100ps
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             ov_reg;
    logic             ov_next;
    logic [WIDTH-1:0] od_reg;
    logic [WIDTH-1:0] od_next;
    logic             push;
    logic             pop;

    // Pointer advance with wrap for any depth
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign push       = in_valid_i && in_ready_o;
    assign pop        = (cnt_reg != '0) && (!ov_reg || out_ready_i);

    // Next pointers, count and head stage
    always_comb begin
        wr_next  = push ? ptr_inc(wr_reg) : wr_reg;
        rd_next  = pop ? ptr_inc(rd_reg) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
        ov_next = (ov_reg && !out_ready_i) || pop;
        od_next = pop ? mem[rd_reg] : od_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
            ov_reg  <= 1'b0;
            od_reg  <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
            ov_reg  <= ov_next;
            od_reg  <= od_next;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
    end

    assign out_valid_o = ov_reg;
    assign out_data_o  = od_reg;
endmodule

// File: design/sync_two_ff.sv
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
module sync_two_ff #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // First stage feeds only the second
    always_comb begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule

// File: test/jtag_data_chains_props.sv
// Port assertions for the test-port data chains
`timescale 1ns/100ps
module jtag_data_chains_props (
    input wire logic        ref_clk_i, rst_n_i, trst_n_i, tdo_oe_o,
    input wire logic        req_valid_o, req_ready_i,
    input wire logic [7:0]  core_out_i, core_oe_i, pad_in_i,
    input wire logic [7:0]  pad_out_o, pad_oe_o, core_in_o,
    input wire logic [34:0] req_data_o,
    input wire logic [1:0]  req_sel_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rst; disable iff (1'h0) !rst_n_i |=> !req_valid_o &&
        !tdo_oe_o && pad_out_o == 8'h00 && pad_oe_o == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_hold; req_valid_o && !req_ready_i |=> req_valid_o; endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_stab; req_valid_o && !req_ready_i |=> $stable(req_data_o)
        && $stable(req_sel_o); endproperty
    a_stab: assert property (p_stab) else $error("request moved");
    property p_sel; req_valid_o |-> req_sel_o != 2'h3; endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    property p_oe; !trst_n_i [*6] |-> !tdo_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("tdo driven");
    property p_po; !trst_n_i [*6] |-> pad_out_o == $past(core_out_i);
    endproperty
    a_po: assert property (p_po) else $error("pad out path");
    property p_poe; !trst_n_i [*6] |-> pad_oe_o == $past(core_oe_i);
    endproperty
    a_poe: assert property (p_poe) else $error("pad oe path");
    property p_ci; !trst_n_i [*6] |-> core_in_o == $past(pad_in_i, 3);
    endproperty
    a_ci: assert property (p_ci) else $error("core in path");
endmodule
bind jtag_data_chains jtag_data_chains_props u_props (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .trst_n_i(trst_n_i),
    .tdo_oe_o(tdo_oe_o), .req_valid_o(req_valid_o), .req_ready_i(req_ready_i),
    .core_out_i(core_out_i), .core_oe_i(core_oe_i), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .core_in_o(core_in_o),
    .req_data_o(req_data_o), .req_sel_o(req_sel_o));

// File: test/jtag_data_chains_test.sv
// Bench for the test-port data chains
`timescale 1ns/100ps
module jtag_data_chains_test;
    logic        clk = 1'h0, rst_n = 1'h0, trst_n = 1'h1, rdy = 1'h0, b;
    logic        tck, tms, tdi, tdo, toe, vld;
    logic [7:0]  pin = 8'hA5, cout = 8'h3C, coe = 8'h0F, pout, poe, cin;
    logic [7:0]  epo, eoe, eci;
    logic [31:0] rdata = 32'hA5C3_0F96;
    logic [2:0]  ack = 3'h2;
    logic [34:0] rq;
    logic [1:0]  sel;
    logic [39:0] q, e;
    int          miscompares = 0, n_checks = 0;
    jtag_data_chains u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
        .tdo_oe_o(toe), .pad_in_i(pin), .core_out_i(cout), .core_oe_i(coe),
        .pad_out_o(pout), .pad_oe_o(poe), .core_in_o(cin),
        .dbg_rdata_i(rdata), .dbg_ack_i(ack), .req_valid_o(vld),
        .req_data_o(rq), .req_sel_o(sel), .req_ready_i(rdy));
    jtag_probe u_probe (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
        .tdo_oe_i(toe));
    initial forever #5 clk = ~clk;
    // Compare and count
    task check(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task ir(input logic [3:0] c);
        u_probe.scan(1, 4, {36'h0, c}, q);
    endtask
    // Test reset with core levels moving, then identity read
    task t_ident;
        @(negedge clk) trst_n = 1'h0;
        repeat (8) @(negedge clk) {cout, pin} = {cout + 8'h11, ~pin};
        trst_n = 1'h1;
        repeat (4) @(negedge clk);
        u_probe.step(1'h0, 1'h0, b);
        u_probe.scan(0, 32, 40'h0, q);
        check(q[31:0], jtag_chain_pkg::ID_VALUE);
        check(q[0], 1'h1);
    endtask
    // Bypass and unassigned codes: one stage capturing zero
    task t_bypass;
        for (int c = 3; c < 16; c++) if (!(c inside {8, 10, 11, 14})) begin
            ir(c[3:0]);
            u_probe.scan(0, 3, 40'h3, q);
            check(q[2:0], 3'h6);
        end
    endtask
    // Sample, preload, then drive pads and core from hold cells
    task t_bsr;
        logic [39:0] pre;
        pre = 40'h0;
        for (int j = 0; j < 8; j++) begin
            e[3*j+:3] = {coe[j], cout[j], pin[j]};
            {eoe[j], epo[j], eci[j]} = 3'h5 ^ j[2:0];
            pre[3*j+:3] = {eoe[j], epo[j], eci[j]};
        end
        ir(jtag_chain_pkg::IR_SAMPLE);
        u_probe.scan(0, 24, pre, q);
        check(q[23:0], e[23:0]);
        ir(jtag_chain_pkg::IR_EXT_TEST);
        check({poe, pout, cin}, {eoe, epo, pin});
        ir(jtag_chain_pkg::IR_INT_TEST);
        check({poe, pout, cin}, {coe, cout, eci});
    endtask
    // One access scan: read side checked, shifted word queued
    task acc(input logic [3:0] c, input logic [34:0] d,
             input logic [34:0] cap);
        ir(c);
        u_probe.scan(0, 35, {5'h0, d}, q);
        check(q[34:0], cap);
    endtask
    // Queue head checked, then taken with one ready clock
    task take(input logic [1:0] s, input logic [34:0] d);
        check({vld, sel, rq}, {1'h1, s, d});
        @(negedge clk) rdy = 1'h1;
        @(negedge clk) rdy = 1'h0;
    endtask
    // Access chains feed the debug-port queue in order
    task t_acc;
        logic [34:0] rd;
        rd = {rdata, ack};
        acc(jtag_chain_pkg::IR_DP_ACC, 35'h1_2345_678B, rd);
        take(jtag_chain_pkg::REQ_DP, 35'h1_2345_678B);
        acc(jtag_chain_pkg::IR_AP_ACC, 35'h6_DCBA_9877, rd);
        acc(jtag_chain_pkg::IR_ABORT, 35'h0_0000_001E, 35'h0);
        take(jtag_chain_pkg::REQ_AP, 35'h6_DCBA_9877);
        take(jtag_chain_pkg::REQ_ABORT, 35'h0_0000_001E);
        check(vld, 1'h0);
    endtask
    // Reset, scenarios in turn, then the verdict
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        u_probe.step(1'h0, 1'h0, b); // Leave reset for idle
        t_bypass;
        t_ident;
        t_bsr;
        t_acc;
        conclude;
    end
    // Watchdog, about three times the expected run
    initial begin
        #100_000;
        miscompares++;
        $display("Error %0t: watchdog expired", $time);
        conclude;
    end
endmodule

// File: test/jtag_probe.sv
// Probe model that drives the test-port link pins
`timescale 1ns/100ps
module jtag_probe (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i
);
    // One 80 ns link period; clock rests low between steps
    task step(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #40 tck_o = 1'h1;
        // read before the fall that moves it
        #39 q = tdo_oe_i ? tdo_i : ~tdo_i;  // Released line reads inverted
        #1 tck_o = 1'h0;
    endtask
    // scan from idle, bits out and in together
    task scan(input bit ir, input int n, input logic [39:0] d,
              output logic [39:0] q);
        logic b;
        q = 40'h0;
        step(1'h1, 1'h0, b);
        if (ir) step(1'h1, 1'h0, b);
        step(1'h0, 1'h0, b);
        step(1'h0, 1'h0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'h1, 1'h0, b);
        step(1'h0, 1'h0, b);
    endtask
    // Idle levels
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
    end
endmodule
